// ### design/sb_pkg.sv
// constants and layouts shared by the shift block design files
//
// Contract
// - with enable inactive, no shift, load or clear happens at all.
// - each accepted pulse loads one entry at its end, others move one stage; the code loads it after the pulse's rising edge.
// - the entry at the far end drops out during a shift and is lost.
// - two formats, one bit or one double word per stage, set by configuration.
// - bit format uses forward/backward bit inputs and eight bit outputs.
// - word format stages and inputs are signed 32-bit values, full range.
// - word outputs show stages one to eight only in word format.
// - forward pulse loads forward input into stage one, stage n moves to n+1.
// - clear while enabled zeroes all eight stages, any format or direction.
// - in bit format word inputs and word outputs have no effect.
// - after reset the format is single bit until word format is chosen.
package sb_pkg;

  localparam int STAGE_COUNT = 8;
  localparam int WORD_W      = 32;
  localparam int CMD_W       = WORD_W + 1;
  localparam int FIFO_DEPTH  = 16;
  localparam int ADDR_W      = 8;
  localparam int COUNT_W     = 5;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] STAGE_BASE    = 8'h20;
  localparam logic [ADDR_W-1:0] STAGE_LAST    = 8'h3C;

  // control fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_MODE_BIT   = 1;
  localparam int CTRL_HOLD_BIT   = 2;
  localparam int CTRL_CLEAR_BIT  = 3;

  // status fields
  localparam int STATUS_EMPTY_BIT = 0;
  localparam int STATUS_FULL_BIT  = 1;
  localparam int STATUS_DROP_BIT  = 2;
  localparam int STATUS_COUNT_LSB = 8;

  // reset values
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam logic CTRL_MODE_RESET   = 1'b0;
  localparam logic CTRL_HOLD_RESET   = 1'b0;

  typedef enum logic {
    SB_DIR_FORWARD,
    SB_DIR_BACKWARD
  } sb_dir_type;

  typedef logic signed [WORD_W-1:0] sb_word_type;

endpackage : sb_pkg

// ### design/sb_edge.sv
// rising edge detector for one shift pulse input
module sb_edge
  import sb_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic level,
  output logic      rise
);

  logic prev;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  // a pulse held high counts once
  assign rise = level & ~prev;

endmodule // sb_edge

// ### design/sb_fifo.sv
// flip-flop fifo with valid/ready on both sides and a flush
module sb_fifo
  import sb_pkg::*;
#(
  parameter int WIDTH = CMD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                       clk_sys,
  input  wire logic                       srst,
  input  wire logic                       flush,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1)-1:0]      count
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (count != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // sb_fifo

// ### design/sb_shift_block.sv
// eight-stage bidirectional shift block with register port
module sb_shift_block
  import sb_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // user control inputs
  input  wire logic              enable,
  input  wire logic              forward_pulse,
  input  wire logic              backward_pulse,
  input  wire logic              clear_input,
  input  wire logic              forward_bit_input,
  input  wire logic              backward_bit_input,
  input  wire logic [WORD_W-1:0] forward_word_input,
  input  wire logic [WORD_W-1:0] backward_word_input,
  output logic                   cmd_ready,
  // bit stage outputs
  output logic                   bit_stage_first,
  output logic                   bit_stage_2,
  output logic                   bit_stage_3,
  output logic                   bit_stage_4,
  output logic                   bit_stage_5,
  output logic                   bit_stage_6,
  output logic                   bit_stage_7,
  output logic                   bit_stage_last,
  // word stage outputs
  output logic [WORD_W-1:0]      word_stage_first,
  output logic [WORD_W-1:0]      word_stage_2,
  output logic [WORD_W-1:0]      word_stage_3,
  output logic [WORD_W-1:0]      word_stage_4,
  output logic [WORD_W-1:0]      word_stage_5,
  output logic [WORD_W-1:0]      word_stage_6,
  output logic [WORD_W-1:0]      word_stage_7,
  output logic [WORD_W-1:0]      word_stage_last,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [WORD_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [WORD_W-1:0]      reg_rdata
);

  // widen one data bit to a stage word
  function automatic sb_word_type widen_bit(input logic b);
    widen_bit = {{(WORD_W-1){1'b0}}, b};
  endfunction

  // stage index of a stage address
  function automatic logic [2:0] stage_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rel;
    rel = a - STAGE_BASE;
    stage_index = rel[4:2];
  endfunction

  sb_word_type            stage [STAGE_COUNT];
  logic                   ctrl_enable;
  logic                   double_word_mode;
  logic                   ctrl_hold;
  logic                   drop_flag;

  logic                   fwd_rise;
  logic                   bwd_rise;
  logic                   active;
  logic                   sw_clear;
  logic                   clear_all;
  logic                   push_valid;
  logic                   push_ready;
  logic                   dropped;
  logic [CMD_W-1:0]       push_cmd;
  sb_word_type            push_word;
  sb_dir_type             push_dir;
  logic                   pop_valid;
  logic                   pop_ready;
  logic                   pop_fire;
  logic [CMD_W-1:0]       pop_cmd;
  sb_dir_type             pop_dir;
  sb_word_type            pop_word;
  logic [COUNT_W-1:0]     fifo_count;
  logic                   ctrl_write;
  logic                   status_write;
  logic [WORD_W-1:0]      next_rdata;
  logic [STAGE_COUNT-1:0] bit_out;
  sb_word_type            word_out [STAGE_COUNT];

  sb_edge u_fwd_edge (
    .clk_sys (clk_sys),
    .srst    (srst),
    .level   (forward_pulse),
    .rise    (fwd_rise)
  );

  sb_edge u_bwd_edge (
    .clk_sys (clk_sys),
    .srst    (srst),
    .level   (backward_pulse),
    .rise    (bwd_rise)
  );

  assign ctrl_write   = reg_wr && (reg_addr == CTRL_OFFSET);
  assign status_write = reg_wr && (reg_addr == STATUS_OFFSET);
  assign sw_clear     = ctrl_write && reg_wdata[CTRL_CLEAR_BIT];

  // both the pin and the control bit must enable the block
  assign active    = enable & ctrl_enable;
  assign clear_all = active & (clear_input | sw_clear);

  // command capture on a pulse edge
  assign push_valid = active & ~clear_all & (fwd_rise | bwd_rise);
  assign push_dir   = fwd_rise ? SB_DIR_FORWARD : SB_DIR_BACKWARD;

  always_comb begin
    push_word = '0;
    if (double_word_mode) begin
      // word inputs used only in word format
      push_word = fwd_rise ? forward_word_input
                           : backward_word_input;
    end else begin
      push_word = fwd_rise ? widen_bit(forward_bit_input)
                           : widen_bit(backward_bit_input);
    end
  end

  assign push_cmd = {push_dir, push_word};
  assign cmd_ready = push_ready;

  // full fifo or simultaneous edges lose a command
  assign dropped = (push_valid & ~push_ready)
                 | (push_valid & fwd_rise & bwd_rise);

  assign pop_ready = active & ~ctrl_hold & ~clear_all;
  assign pop_fire  = pop_valid & pop_ready;
  assign pop_dir   = sb_dir_type'(pop_cmd[CMD_W-1]);
  assign pop_word  = pop_cmd[WORD_W-1:0];

  sb_fifo #(
    .WIDTH (CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .flush     (clear_all),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_cmd),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_cmd),
    .count     (fifo_count)
  );

  // stage storage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < STAGE_COUNT; i++) begin
        stage[i] <= '0;
      end
    end else if (clear_all) begin
      for (int i = 0; i < STAGE_COUNT; i++) begin
        stage[i] <= '0;
      end
    end else if (pop_fire) begin
      if (pop_dir == SB_DIR_FORWARD) begin
        // last stage falls off the end
        for (int i = STAGE_COUNT - 1; i > 0; i--) begin
          stage[i] <= stage[i-1];
        end
        stage[0] <= pop_word;
      end else begin
        // first stage falls off the end
        for (int i = 0; i < STAGE_COUNT - 1; i++) begin
          stage[i] <= stage[i+1];
        end
        stage[STAGE_COUNT-1] <= pop_word;
      end
    end
  end

  // registered outputs, gated by format
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bit_out <= '0;
      for (int i = 0; i < STAGE_COUNT; i++) begin
        word_out[i] <= '0;
      end
    end else begin
      for (int i = 0; i < STAGE_COUNT; i++) begin
        bit_out[i]  <= ~double_word_mode & stage[i][0];
        word_out[i] <= double_word_mode ? stage[i] : '0;
      end
    end
  end

  assign bit_stage_first  = bit_out[0];
  assign bit_stage_2      = bit_out[1];
  assign bit_stage_3      = bit_out[2];
  assign bit_stage_4      = bit_out[3];
  assign bit_stage_5      = bit_out[4];
  assign bit_stage_6      = bit_out[5];
  assign bit_stage_7      = bit_out[6];
  assign bit_stage_last   = bit_out[7];
  assign word_stage_first = word_out[0];
  assign word_stage_2     = word_out[1];
  assign word_stage_3     = word_out[2];
  assign word_stage_4     = word_out[3];
  assign word_stage_5     = word_out[4];
  assign word_stage_6     = word_out[5];
  assign word_stage_7     = word_out[6];
  assign word_stage_last  = word_out[7];

  // control register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_enable      <= CTRL_ENABLE_RESET;
      double_word_mode <= CTRL_MODE_RESET;
      ctrl_hold        <= CTRL_HOLD_RESET;
    end else if (ctrl_write) begin
      ctrl_enable      <= reg_wdata[CTRL_ENABLE_BIT];
      double_word_mode <= reg_wdata[CTRL_MODE_BIT];
      ctrl_hold        <= reg_wdata[CTRL_HOLD_BIT];
    end
  end

  // sticky drop flag, set wins over write-one clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      drop_flag <= 1'b0;
    end else if (dropped) begin
      drop_flag <= 1'b1;
    end else if (status_write && reg_wdata[STATUS_DROP_BIT]) begin
      drop_flag <= 1'b0;
    end
  end

  // read decode
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      if (reg_addr == CTRL_OFFSET) begin
        next_rdata[CTRL_ENABLE_BIT] = ctrl_enable;
        next_rdata[CTRL_MODE_BIT]   = double_word_mode;
        next_rdata[CTRL_HOLD_BIT]   = ctrl_hold;
      end else if (reg_addr == STATUS_OFFSET) begin
        next_rdata[STATUS_EMPTY_BIT] = ~pop_valid;
        next_rdata[STATUS_FULL_BIT]  = ~push_ready;
        next_rdata[STATUS_DROP_BIT]  = drop_flag;
        next_rdata[STATUS_COUNT_LSB +: COUNT_W] = fifo_count;
      end else if ((reg_addr >= STAGE_BASE) && (reg_addr <= STAGE_LAST)
                   && (reg_addr[1:0] == 2'b00)) begin
        next_rdata = stage[stage_index(reg_addr)];
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // sb_shift_block

// ### verification/sb_shift_block_properties.sv
// port properties of the shift block
module sb_shift_block_chk
  import sb_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              srst,
  input wire logic              enable,
  input wire logic              forward_pulse,
  input wire logic              backward_pulse,
  input wire logic              clear_input,
  input wire logic              forward_bit_input,
  input wire logic [WORD_W-1:0] forward_word_input,
  input wire logic              reg_rd,
  input wire logic              reg_wr,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [WORD_W-1:0] reg_wdata,
  input wire logic [WORD_W-1:0] reg_rdata,
  input wire logic              cmd_ready,
  input wire logic              bit_stage_first,
  input wire logic              bit_stage_last,
  input wire logic [WORD_W-1:0] word_stage_first,
  input wire logic [WORD_W-1:0] word_stage_2,
  input wire logic [WORD_W-1:0] word_stage_7,
  input wire logic [WORD_W-1:0] word_stage_last
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic zero;
  logic sw_en;
  logic sw_hold;
  logic sw_clr;
  logic run;
  logic go;
  assign zero = !bit_stage_first && !bit_stage_last && word_stage_first == '0
    && word_stage_2 == '0 && word_stage_7 == '0 && word_stage_last == '0;
  // software enable and hold, tracked from control writes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sw_en   <= CTRL_ENABLE_RESET;
      sw_hold <= CTRL_HOLD_RESET;
    end else if (reg_wr && reg_addr == CTRL_OFFSET) begin
      sw_en   <= reg_wdata[CTRL_ENABLE_BIT];
      sw_hold <= reg_wdata[CTRL_HOLD_BIT];
    end
  end
  assign sw_clr = reg_wr && reg_addr == CTRL_OFFSET
    && reg_wdata[CTRL_CLEAR_BIT];
  assign run = enable && sw_en;
  assign go  = run && !sw_hold && !clear_input && !sw_clr;
  sequence s_fwd_edge;
    $rose(forward_pulse) && !backward_pulse && go;
  endsequence
  sequence s_settle;
    (go && !$rose(backward_pulse)) [*2];
  endsequence
  sequence s_clear;
    (clear_input || sw_clr) && run;
  endsequence
  property p_reset_zero;
    $fell(srst) |-> zero && cmd_ready;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("outputs not idle after reset");
  property p_clear;
    s_clear |-> ##2 zero;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear left stages nonzero");
  property p_clear_wins;
    clear_input && run && $rose(forward_pulse) |-> ##3 zero;
  endproperty
  a_clear_wins: assert property (p_clear_wins)
    else $error("shift beat clear");
  property p_fwd;
    s_fwd_edge ##1 s_settle |-> ##1 (word_stage_2 == $past(word_stage_first)
      && word_stage_last == $past(word_stage_7) && (bit_stage_first ==
      $past(forward_bit_input, 3) || word_stage_first ==
      $past(forward_word_input, 3)));
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("forward shift wrong");
  property p_mode_excl;
    bit_stage_first || bit_stage_last |->
      word_stage_first == '0 && word_stage_last == '0;
  endproperty
  a_mode_excl: assert property (p_mode_excl)
    else $error("word outputs active in bit format");
  property p_frozen;
    !enable [*4] |-> $stable(word_stage_first) && $stable(bit_stage_first)
      && $stable(bit_stage_last);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("stages moved while disabled");
  property p_one_shift;
    (forward_pulse && !backward_pulse && !clear_input) [*5] |->
      $stable(word_stage_first) && $stable(bit_stage_first);
  endproperty
  a_one_shift: assert property (p_one_shift)
    else $error("held pulse shifted again");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
endmodule // sb_shift_block_chk

bind sb_shift_block sb_shift_block_chk i_chk (
  .clk_sys            (clk_sys),
  .srst               (srst),
  .enable             (enable),
  .forward_pulse      (forward_pulse),
  .backward_pulse     (backward_pulse),
  .clear_input        (clear_input),
  .forward_bit_input  (forward_bit_input),
  .forward_word_input (forward_word_input),
  .reg_rd             (reg_rd),
  .reg_wr             (reg_wr),
  .reg_addr           (reg_addr),
  .reg_wdata          (reg_wdata),
  .reg_rdata          (reg_rdata),
  .cmd_ready          (cmd_ready),
  .bit_stage_first    (bit_stage_first),
  .bit_stage_last     (bit_stage_last),
  .word_stage_first   (word_stage_first),
  .word_stage_2       (word_stage_2),
  .word_stage_7       (word_stage_7),
  .word_stage_last    (word_stage_last)
);

// ### verification/sb_user_model.sv
// user control logic model driving shift pulses and data
module sb_user_model
  import sb_pkg::*;
(
  input  wire logic  clk_sys,
  output logic       forward_pulse,
  output logic       backward_pulse,
  output logic       forward_bit_input,
  output logic       backward_bit_input,
  output logic [31:0] forward_word_input,
  output logic [31:0] backward_word_input
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    forward_pulse = 1'h0;
    backward_pulse = 1'h0;
    forward_bit_input = 1'h0;
    backward_bit_input = 1'h0;
    forward_word_input = 32'h0;
    backward_word_input = 32'h0;
  end
  // data set first, pulse high for hi edges, then low
  task automatic shift(input logic dir, input logic b, input logic [31:0] w,
                       input int gap, input int hi);
    @(posedge clk_sys);
    forward_bit_input <= b;
    backward_bit_input <= b;
    forward_word_input <= w;
    backward_word_input <= w;
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    if (dir) begin
      backward_pulse <= 1'h1;
    end else begin
      forward_pulse <= 1'h1;
    end
    repeat (hi) @(posedge clk_sys);
    forward_pulse <= 1'h0;
    backward_pulse <= 1'h0;
  endtask
endmodule // sb_user_model

// ### verification/tb_sb_shift_block.sv
// self-checking bench for the shift block
module tb_sb_shift_block
  import sb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  logic enable = 1'h1;
  logic clear_input = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [WORD_W-1:0] reg_wdata = '0;
  logic [WORD_W-1:0] reg_rdata, words_or;
  logic cmd_ready, forward_pulse, backward_pulse;
  logic forward_bit_input, backward_bit_input;
  logic [WORD_W-1:0] forward_word_input, backward_word_input;
  logic bit_stage_first, bit_stage_2, bit_stage_3, bit_stage_4;
  logic bit_stage_5, bit_stage_6, bit_stage_7, bit_stage_last;
  logic [WORD_W-1:0] word_stage_first, word_stage_2, word_stage_3;
  logic [WORD_W-1:0] word_stage_4, word_stage_5, word_stage_6;
  logic [WORD_W-1:0] word_stage_7, word_stage_last;
  logic [WORD_W-1:0] bv;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  assign bv = {24'h0, bit_stage_last, bit_stage_7, bit_stage_6, bit_stage_5,
               bit_stage_4, bit_stage_3, bit_stage_2, bit_stage_first};
  assign words_or = word_stage_first | word_stage_2 | word_stage_3
    | word_stage_4 | word_stage_5 | word_stage_6 | word_stage_7
    | word_stage_last;
  sb_shift_block i_dut (.*);
  sb_user_model i_user (.*);
  always #5 clk_sys = ~clk_sys;
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic sh(input logic d, input logic b, input logic [31:0] w,
                    input int hi);
    i_user.shift(d, b, w, 0, hi);
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic pin(input logic en, input logic clr);
    @(posedge clk_sys);
    enable <= en;
    clear_input <= clr;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'h0;
    rd(CTRL_OFFSET, 32'h1);
    rd(STATUS_OFFSET, 32'h1);
    wr(8'h10, 32'hF);
    rd(8'h10, 32'h0);
    sh(1'h0, 1'h1, 32'hA5, 1);
    sh(1'h0, 1'h0, 32'hA5, 1);
    sh(1'h0, 1'h1, 32'hA5, 1);
    check(bv, 32'h5);
    check(words_or, 32'h0);
    sh(1'h1, 1'h1, 32'h5A, 1);
    check(bv, 32'h82);
    pin(1'h0, 1'h0);
    sh(1'h0, 1'h1, 32'h0, 1);
    pin(1'h0, 1'h1);
    pin(1'h1, 1'h0);
    repeat (2) @(posedge clk_sys);
    #1 check(bv, 32'h82);
    pin(1'h1, 1'h1);
    pin(1'h1, 1'h0);
    sh(1'h0, 1'h0, 32'h0, 1);
    check(bv, 32'h0);
    wr(CTRL_OFFSET, 32'h3);
    sh(1'h0, 1'h0, 32'hA, 1);
    sh(1'h0, 1'h0, 32'h34, 1);
    check(word_stage_2, 32'hA);
    sh(1'h0, 1'h0, 32'h80000000, 1);
    sh(1'h1, 1'h0, 32'h7FFFFFFF, 1);
    check(word_stage_first, 32'h34);
    check(word_stage_3, 32'h0);
    check(word_stage_last, 32'h7FFFFFFF);
    check(bv, 32'h0);
    rd(STAGE_LAST, 32'h7FFFFFFF);
    wr(CTRL_OFFSET, 32'hB);
    rd(CTRL_OFFSET, 32'h3);
    check(words_or, 32'h0);
    fork
      sh(1'h0, 1'h0, 32'h77, 1);
      pin(1'h1, 1'h0);
      begin
        repeat (2) @(posedge clk_sys);
        clear_input <= 1'h1;
        @(posedge clk_sys);
        clear_input <= 1'h0;
      end
    join
    check(words_or, 32'h0);
    sh(1'h0, 1'h0, 32'h7, 6);
    check(word_stage_first, 32'h7);
    check(word_stage_2, 32'h0);
    wr(CTRL_OFFSET, 32'h2);
    sh(1'h0, 1'h0, 32'h99, 1);
    wr(CTRL_OFFSET, 32'h3);
    rd(STAGE_BASE, 32'h7);
    wr(CTRL_OFFSET, 32'h7);
    for (int i = 0; i < 17; i++) begin
      i_user.shift(1'h1, 1'h0, 32'(i), 0, 1);
    end
    #1 check({31'h0, cmd_ready}, 32'h0);
    rd(STATUS_OFFSET, 32'h1006);
    wr(CTRL_OFFSET, 32'h3);
    repeat (20) @(posedge clk_sys);
    rd(STATUS_OFFSET, 32'h5);
    check(word_stage_last, 32'hF);
    check(word_stage_first, 32'h8);
    wr(STATUS_OFFSET, 32'h4);
    rd(STATUS_OFFSET, 32'h1);
    summarize();
  end
endmodule // tb_sb_shift_block
